// ---- nvrmi_pkg.sv ----
// nvrmi_pkg: constants for the host controller of the read/modify nv memory
package nvrmi_pkg;
	// ==========================================
	// organisation
	localparam int NVRMI_ADDR_W = 8;
	localparam int NVRMI_DATA_W = 4;
	localparam int NVRMI_WORDS = 256;
	// ==========================================
	// timing, figures in ns (fast grade) except modify maximum in ms, clock 4 ns
	localparam int NVRMI_CLK_NS = 4;
	localparam int NVRMI_ACCESS_NS = 450;
	localparam int NVRMI_STROBE_LOW_NS = 450;
	localparam int NVRMI_STROBE_HIGH_NS = 160;
	localparam int NVRMI_DIR_DELAY_MIN_NS = 100;
	localparam int NVRMI_DIR_DELAY_MAX_NS = 350;
	localparam int NVRMI_PULSE_NS = 200;
	localparam int NVRMI_DONE_TURN_ON_NS = 100;
	localparam int NVRMI_MODIFY_MAX_MS = 100;
	// least times round up, longest round down
	localparam int NVRMI_ACCESS_CYC = (NVRMI_ACCESS_NS + NVRMI_CLK_NS - 1) / NVRMI_CLK_NS;
	localparam int NVRMI_STROBE_LOW_CYC = (NVRMI_STROBE_LOW_NS + NVRMI_CLK_NS - 1) / NVRMI_CLK_NS;
	localparam int NVRMI_STROBE_HIGH_CYC = (NVRMI_STROBE_HIGH_NS + NVRMI_CLK_NS - 1) / NVRMI_CLK_NS;
	// direction falls midway inside the allowed strobe-to-direction window
	localparam int NVRMI_DIR_DELAY_CYC =
		(NVRMI_DIR_DELAY_MIN_NS + NVRMI_DIR_DELAY_MAX_NS) / 2 / NVRMI_CLK_NS;
	localparam int NVRMI_PULSE_CYC = (NVRMI_PULSE_NS + NVRMI_CLK_NS - 1) / NVRMI_CLK_NS;
	localparam int NVRMI_DONE_CYC = (NVRMI_DONE_TURN_ON_NS + NVRMI_CLK_NS - 1) / NVRMI_CLK_NS;
	localparam int NVRMI_TIMEOUT_CYC = NVRMI_MODIFY_MAX_MS * 1000000 / NVRMI_CLK_NS;
	localparam int NVRMI_CNT_W = 32;
	// ==========================================
	// controller states
	typedef enum logic [2:0] {
		NVRMI_IDLE = 3'b000,
		NVRMI_LOW = 3'b001,
		NVRMI_DIR = 3'b010,
		NVRMI_TAIL = 3'b011,
		NVRMI_GAP = 3'b100,
		NVRMI_BUSY = 3'b101
	} nvrmi_state_t;
endpackage

// ---- nvrmi_timer_if.sv ----
// nvrmi_timer_if: load and expiry signals between controller and its timer
`timescale 1ns/1ps
`default_nettype none
interface nvrmi_timer_if;
	import nvrmi_pkg::*;
	logic load;
	logic [NVRMI_CNT_W-1:0] count;
	logic expired;
	modport ctrl (output load, output count, input expired);
	modport timer (input load, input count, output expired);
endinterface
`default_nettype wire

// ---- nvrmi_timer.sv ----
// nvrmi_timer: down counter telling the controller when a wait is over
`timescale 1ns/1ps
`default_nettype none
module nvrmi_timer
	import nvrmi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	nvrmi_timer_if.timer tif
);
	logic [NVRMI_CNT_W-1:0] cnt_q;
	logic [NVRMI_CNT_W-1:0] cnt_d;

	// ==========================================
	// count down, expired while zero
	assign cnt_d = tif.load ? tif.count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
	// expiry reads the count only, so the load path cannot loop back into it
	assign tif.expired = (cnt_q == '0);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// ---- nvrmi_host.sv ----
// nvrmi_host: host controller running read and modify cycles on the nv memory
// How it works
// - strobe fall starts cycle; direction picks kind
// - write data captured on direction rising edge
// - strobe held low at least 450 ns
// - strobe held high at least 160 ns
// - direction low pulse at least 200 ns
// - after flag rises, wait strobe high time
`timescale 1ns/1ps
`default_nettype none
module nvrmi_host
	import nvrmi_pkg::*;
#(
	parameter int TIMEOUT_CYC = NVRMI_TIMEOUT_CYC
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [NVRMI_ADDR_W-1:0] req_addr,
	input wire logic [NVRMI_DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [NVRMI_DATA_W-1:0] rsp_rdata,
	output logic rsp_timeout,
	output logic address_strobe_n,
	output logic direction,
	output logic [NVRMI_ADDR_W-1:0] addr_out,
	input wire logic [NVRMI_DATA_W-1:0] data_in,
	output logic [NVRMI_DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic modify_done_flag
);
	// refuse a timeout no longer than the flag turn-on delay
	if (TIMEOUT_CYC < NVRMI_DONE_CYC + 1) begin : g_bad_timeout
		$error("TIMEOUT_CYC too small");
	end

	nvrmi_timer_if tif ();
	nvrmi_timer u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.tif(tif)
	);

	nvrmi_state_t state_q, state_d;
	logic write_q;
	logic [NVRMI_ADDR_W-1:0] addr_q;
	logic [NVRMI_DATA_W-1:0] wdata_q;
	logic [NVRMI_DATA_W-1:0] rdata_q;
	logic rsp_valid_q;
	logic timeout_q;
	logic done_flag_seen_q;
	logic as_n_q, as_n_d;
	logic dir_q, dir_d;
	logic oe_q, oe_d;
	logic [2:0] done_sync_q;
	logic [NVRMI_DATA_W-1:0] din_s1_q, din_s2_q, din_s3_q, din_seen_q;
	logic done_s;
	logic start;
	logic load_d;
	logic [NVRMI_CNT_W-1:0] count_d;
	logic setup_q;
	logic busy_low_q;
	logic busy_exit;

	// ==========================================
	// pin inputs: three flops, change counts when stages two and three agree
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done_sync_q <= 3'h7;
			done_flag_seen_q <= 1'b1;
			din_s1_q <= '0;
			din_s2_q <= '0;
			din_s3_q <= '0;
			din_seen_q <= '0;
		end else begin
			done_sync_q <= {done_sync_q[1:0], modify_done_flag};
			if (done_sync_q[1] == done_sync_q[2]) begin
				done_flag_seen_q <= done_sync_q[2];
			end
			din_s1_q <= data_in;
			din_s2_q <= din_s1_q;
			din_s3_q <= din_s2_q;
			if (din_s2_q == din_s3_q) begin
				din_seen_q <= din_s3_q;
			end
		end
	end
	assign done_s = done_flag_seen_q;

	// ==========================================
	// request handshake: no new cycle while device busy
	assign req_ready = (state_q == NVRMI_IDLE) && done_s && tif.expired;
	assign start = req_valid && req_ready;
	// modify over: flag came back after going low, or the wait ran out
	assign busy_exit = (state_q == NVRMI_BUSY) && ((busy_low_q && done_s) || tif.expired);

	// ==========================================
	// cycle sequencer
	always_comb begin
		state_d = state_q;
		as_n_d = as_n_q;
		dir_d = dir_q;
		oe_d = oe_q;
		load_d = 1'b0;
		count_d = '0;
		case (state_q)
			NVRMI_IDLE: begin
				if (!done_s) begin
					// flag low outside a modify: restart the strobe high wait
					load_d = 1'b1;
					count_d = NVRMI_CNT_W'(NVRMI_STROBE_HIGH_CYC);
				end else if (start) begin
					load_d = 1'b1;
					// modify: wait into strobe-to-direction window; read: strobe low time
					count_d = req_write ? NVRMI_CNT_W'(NVRMI_DIR_DELAY_CYC) :
						NVRMI_CNT_W'(NVRMI_STROBE_LOW_CYC);
					state_d = req_write ? NVRMI_DIR : NVRMI_LOW;
				end
			end
			NVRMI_LOW: begin
				if (tif.expired) begin
					as_n_d = 1'b1;
					load_d = 1'b1;
					count_d = NVRMI_CNT_W'(NVRMI_STROBE_HIGH_CYC);
					state_d = NVRMI_GAP;
				end
			end
			NVRMI_DIR: begin
				if (tif.expired && !dir_q) begin
					// direction falls inside the window, data driven now
					dir_d = 1'b1;
					oe_d = 1'b1;
					load_d = 1'b1;
					count_d = NVRMI_CNT_W'(NVRMI_STROBE_LOW_CYC);
					state_d = NVRMI_TAIL;
				end
			end
			NVRMI_TAIL: begin
				if (tif.expired) begin
					// direction rise latches write data
					dir_d = 1'b0;
					as_n_d = 1'b1;
					oe_d = 1'b0;
					load_d = 1'b1;
					count_d = NVRMI_CNT_W'(TIMEOUT_CYC);
					state_d = NVRMI_BUSY;
				end
			end
			NVRMI_BUSY: begin
				if (busy_exit) begin
					// wait strobe high time after flag rises
					load_d = 1'b1;
					count_d = NVRMI_CNT_W'(NVRMI_STROBE_HIGH_CYC);
					state_d = NVRMI_GAP;
				end
			end
			NVRMI_GAP: begin
				if (tif.expired) begin
					state_d = NVRMI_IDLE;
				end
			end
			default: begin
				state_d = NVRMI_IDLE;
			end
		endcase
		// strobe falls one cycle after the address, so it is settled at the latch
		if (setup_q) begin
			as_n_d = 1'b0;
		end
	end

	// ==========================================
	// state and pins; busy_low remembers the flag went low, exit clears it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= NVRMI_IDLE;
			as_n_q <= 1'b1;
			dir_q <= 1'b0;
			oe_q <= 1'b0;
			setup_q <= 1'b0;
			busy_low_q <= 1'b0;
		end else begin
			state_q <= state_d;
			as_n_q <= as_n_d;
			dir_q <= dir_d;
			oe_q <= oe_d;
			setup_q <= start;
			if ((state_q == NVRMI_BUSY) && !done_s) begin
				busy_low_q <= 1'b1;
			end
			if (busy_exit) begin
				busy_low_q <= 1'b0;
			end
		end
	end

	assign tif.load = load_d;
	assign tif.count = count_d;

	// ==========================================
	// request capture and answers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			write_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			rsp_valid_q <= 1'b0;
			timeout_q <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			if (start) begin
				write_q <= req_write;
				addr_q <= req_addr;
				wdata_q <= req_wdata;
				timeout_q <= 1'b0;
			end
			if (state_q == NVRMI_LOW && tif.expired) begin
				// device output latch holds data; sample at strobe end
				rdata_q <= din_seen_q;
				rsp_valid_q <= 1'b1;
			end
			if (busy_exit) begin
				// device stores the written bits as given; host just reports completion
				rsp_valid_q <= 1'b1;
				timeout_q <= !(busy_low_q && done_s);
			end
		end
	end

	// strobe may stay low indefinitely; host keeps its own length
	assign address_strobe_n = as_n_q;
	assign direction = !dir_q;
	assign addr_out = addr_q;
	assign data_out = wdata_q;
	assign data_oe = oe_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_rdata = rdata_q;
	assign rsp_timeout = timeout_q;
endmodule
`default_nettype wire

// ---- nvrmi_host_props.sv ----
// nvrmi_host_props: pin timing checks for the nv memory host controller
`timescale 1ns/1ps
`default_nettype none
module nvrmi_host_props
	import nvrmi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic rsp_timeout,
	input wire logic address_strobe_n,
	input wire logic direction,
	input wire logic [NVRMI_ADDR_W-1:0] addr_out,
	input wire logic data_oe,
	input wire logic modify_done_flag
);
	// ==========================================
	// helper counters
	logic [7:0] low_q, low_d, high_q, high_d, dlow_q, dlow_d, fhi_q, fhi_d;
	logic wr_q, wr_d;
	// saturating counts of strobe low, strobe high, direction low, flag high
	assign low_d = address_strobe_n ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
	assign high_d = !address_strobe_n ? 8'h00 : high_q + {7'h00, high_q != 8'hff};
	assign dlow_d = direction ? 8'h00 : dlow_q + {7'h00, dlow_q != 8'hff};
	assign fhi_d = !modify_done_flag ? 8'h00 : fhi_q + {7'h00, fhi_q != 8'hff};
	assign wr_d = !direction | (wr_q & !req_ready);
	// gaps start as satisfied so the first cycle after reset is legal
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{low_q, dlow_q, wr_q} <= '0;
			{high_q, fhi_q} <= {8'h28, 8'h28};
		end else begin
			{low_q, high_q, dlow_q, fhi_q, wr_q} <= {low_d, high_d, dlow_d, fhi_d, wr_d};
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_LOW_MIN: assert property ($rose(address_strobe_n) |-> low_q >= 8'h71)
		else $error("strobe low time too short");
	AST_HIGH_MIN: assert property ($fell(address_strobe_n) |-> high_q >= 8'h28)
		else $error("strobe high time too short");
	AST_FLAG_GAP: assert property ($fell(address_strobe_n) |-> fhi_q >= 8'h28)
		else $error("strobe fell too soon after modify end");
	AST_DIR_WIN: assert property ($fell(direction) |-> low_q inside {[8'h19:8'h57]})
		else $error("direction fell outside its window");
	AST_PULSE: assert property ($rose(direction) |-> dlow_q >= 8'h32)
		else $error("modify pulse too short");
	AST_DIR_CYCLE: assert property (!direction |-> !address_strobe_n && data_oe)
		else $error("direction low outside a driven cycle");
	AST_OE_CYCLE: assert property (data_oe |-> !direction)
		else $error("data driven outside modify pulse");
	AST_READ_RSP: assert property ($rose(address_strobe_n) && !wr_q |-> rsp_valid)
		else $error("read answer missing");
	AST_BUSY: assert property (!modify_done_flag [*5] |-> !req_ready)
		else $error("ready while device busy");
	AST_ADDR_HOLD: assert property (!address_strobe_n |-> $stable(addr_out))
		else $error("address moved during strobe");
	AST_ADDR_SETUP: assert property ($fell(address_strobe_n) |-> $stable(addr_out))
		else $error("address changed with strobe fall");
	C_READ: cover property ($rose(address_strobe_n) && !wr_q);
	C_MODIFY: cover property ($rose(direction));
	C_TIMEOUT: cover property (rsp_valid && rsp_timeout);
endmodule
bind nvrmi_host nvrmi_host_props u_props (.sys_clk(sys_clk), .rst(rst), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .rsp_timeout(rsp_timeout), .address_strobe_n(address_strobe_n),
	.direction(direction), .addr_out(addr_out), .data_oe(data_oe),
	.modify_done_flag(modify_done_flag));
`default_nettype wire

// ---- nvrmi_dev_model.sv ----
// nvrmi_dev_model: behavioural read/modify nv memory on the host pins
`timescale 1ns/1ps
`default_nettype none
module nvrmi_dev_model #(
	parameter int FAST_NS = 2000,
	parameter int SLOW_NS = 6000
) (
	input wire logic address_strobe_n,
	input wire logic direction,
	input wire logic [7:0] addr,
	input wire logic [3:0] bus,
	input wire logic slow,
	input wire logic stuck,
	output logic [3:0] dev_data,
	output logic dev_oe,
	output logic modify_done_flag
);
	// ==========================================
	// storage and cycles
	logic [3:0] mem [256];
	logic [7:0] a_q;
	logic [3:0] d_q, old_q, hold_q;
	// preload pattern, bus released, flag high
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[3:0] ^ i[7:4];
		{dev_oe, dev_data, modify_done_flag} = 6'h01;
	end
	// bus as it stood just before now, so a release in the same step cannot win
	always @(bus) hold_q <= #1 bus;
	// one cycle per strobe fall, deaf while a modify runs
	always @(negedge address_strobe_n) if (modify_done_flag) begin
		a_q = addr;
		#350;
		if (direction) begin
			#50 dev_data = mem[a_q];
			dev_oe = 1'b1;
			@(posedge address_strobe_n) #20 dev_oe = 1'b0;
		end else begin
			@(posedge direction) d_q = hold_q;
			old_q = mem[a_q];
			#20 modify_done_flag = 1'b0;
			#(slow ? SLOW_NS : FAST_NS);
			mem[a_q] = (old_q | (d_q & ~old_q)) & ~(old_q & ~d_q);
			wait (!stuck) modify_done_flag = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the nv memory host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top
	import nvrmi_pkg::*;
;
	// ==========================================
	// bench
	typedef struct packed {logic rd; logic [3:0] d; logic to;} nvrmi_note_t;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0, req_write = 1'b0, slow = 1'b0, stuck = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [3:0] req_wdata = 4'h0;
	logic req_ready, rsp_valid, rsp_timeout, address_strobe_n, direction, data_oe, dev_oe;
	logic modify_done_flag;
	logic [7:0] addr_out;
	logic [3:0] rsp_rdata, data_out, dev_data, bus;
	logic [3:0] shadow [256];
	logic [31:0] rv;
	nvrmi_note_t notes [$];
	nvrmi_note_t cur;
	int n_mismatch = 0, num_checks = 0;
	// open-drain data lines with pull-up, wired and
	assign bus = (data_oe ? data_out : 4'hf) & (dev_oe ? dev_data : 4'hf);
	always #2 sys_clk = ~sys_clk;
	nvrmi_host #(.TIMEOUT_CYC(2000)) uut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_timeout(rsp_timeout), .address_strobe_n(address_strobe_n), .direction(direction),
		.addr_out(addr_out), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
		.modify_done_flag(modify_done_flag));
	nvrmi_dev_model dev (.address_strobe_n(address_strobe_n), .direction(direction),
		.addr(addr_out), .bus(bus), .slow(slow), .stuck(stuck), .dev_data(dev_data),
		.dev_oe(dev_oe), .modify_done_flag(modify_done_flag));
	// compare each answer with the oldest note
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) begin
			`CHK(notes.size() > 0, 1'b1)
			cur = notes.pop_front();
			`CHK(rsp_timeout, cur.to)
			if (cur.rd) `CHK(rsp_rdata, cur.d)
		end
	end
	// one request once ready, noting its answer
	task automatic op(input logic w, input logic [7:0] a, input logic [3:0] d, input logic to);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 20000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 20000) n_mismatch++;
		{req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
		notes.push_back(nvrmi_note_t'{!w, w ? 4'h0 : shadow[a], to});
		if (w) shadow[a] = d;
		@(negedge sys_clk);
		req_valid = 1'b0;
		`CHK(req_ready, 1'b0)
	endtask
	task automatic drain;
		int k;
		k = 0;
		while (notes.size() != 0 && k < 3000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 3000) n_mismatch++;
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		#200000;
		n_mismatch++;
		end_of_test;
	end
	// read, modify and read back, slow and stuck modify, random mix
	initial begin
		rv = $urandom(32'h4185);
		for (int i = 0; i < 256; i++) shadow[i] = i[3:0] ^ i[7:4];
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		rv = $urandom;
		op(1'b0, rv[7:0], 4'h0, 1'b0);
		op(1'b1, rv[7:0], ~shadow[rv[7:0]], 1'b0);
		op(1'b0, rv[7:0], 4'h0, 1'b0);
		slow = 1'b1;
		op(1'b1, 8'hff, rv[11:8], 1'b0);
		op(1'b0, 8'hff, 4'h0, 1'b0);
		drain;
		slow = 1'b0;
		stuck = 1'b1;
		op(1'b1, 8'h00, rv[15:12], 1'b1);
		drain;
		stuck = 1'b0;
		op(1'b0, 8'h00, 4'h0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rv = $urandom;
			op(rv[0], rv[15:8], rv[7:4], 1'b0);
		end
		drain;
		end_of_test;
	end
endmodule
`default_nettype wire
